/* adc_ctrl_pkg.sv */
// constants, field positions and types shared by the conversion control files
package adc_ctrl_pkg;

    // ****************************************************************
    // register offsets (byte bus)
    // ****************************************************************
    localparam int ADDR_W = 3;
    localparam logic [2:0] OFS_SC1 = 3'h0;
    localparam logic [2:0] OFS_SC2 = 3'h1;
    localparam logic [2:0] OFS_RES_HIGH = 3'h2;
    localparam logic [2:0] OFS_RES_LOW = 3'h3;
    localparam logic [2:0] OFS_CMP_HIGH = 3'h4;
    localparam logic [2:0] OFS_CMP_LOW = 3'h5;
    localparam logic [2:0] OFS_CFG = 3'h6;
    localparam logic [2:0] OFS_PIN_DIS = 3'h7;

    // ****************************************************************
    // field positions and reset values
    // ****************************************************************
    localparam int SC1_CONVERSION_COMPLETE_FLAG_BIT = 7;
    localparam int SC1_COMPLETE_INTERRUPT_ENABLE_BIT = 6;
    localparam int SC1_CONT_BIT = 5;
    localparam logic [4:0] CH_OFF = 5'h1f;
    localparam int SC2_ACTIVE_BIT = 7;
    localparam int SC2_TRG_BIT = 6;
    localparam int SC2_CFE_BIT = 5;
    localparam int SC2_CFGT_BIT = 4;
    localparam int CFG_DIV_LSB = 5;
    localparam int CFG_LSMP_BIT = 4;
    localparam int CFG_MODE_LSB = 2;
    localparam int CFG_ICLK_LSB = 0;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [7:0] FULL_BYTE = 8'hff;

    // ****************************************************************
    // modes and states
    // ****************************************************************
    typedef enum logic [1:0] {
        MODE_8 = 2'b00,
        MODE_12 = 2'b01,
        MODE_10 = 2'b10,
        MODE_RSVD = 2'b11
    } conv_mode_t;

    typedef enum logic [1:0] {
        SRC_BUS = 2'b00,
        SRC_BUS_HALF = 2'b01,
        SRC_ALT = 2'b10,
        SRC_ASYNC = 2'b11
    } clk_src_t;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_SAMPLE = 2'b01,
        SEQ_CONVERT = 2'b10
    } seq_t;

    // ****************************************************************
    // timing: sample time in tenths of converter clock cycles
    // ****************************************************************
    localparam int SAMPLE_SHORT_TENTHS = 35;
    localparam int SAMPLE_LONG_TENTHS = 235;
    localparam logic [4:0] SAMPLE_SHORT_TICKS = 5'((SAMPLE_SHORT_TENTHS + 9) / 10);
    localparam logic [4:0] SAMPLE_LONG_TICKS = 5'((SAMPLE_LONG_TENTHS + 9) / 10);
    localparam logic [3:0] MSB_12 = 4'hb;
    localparam logic [3:0] MSB_9 = 4'h8;

endpackage

/* conv_tick_if.sv */
// carrier between the sequencer and the converter clock generator
`timescale 1ns/1ps
interface conv_tick_if;
    logic [1:0] source_sel;
    logic [1:0] divide_sel;
    logic run;
    logic alt_level;
    logic async_level;
    logic tick;
    modport gen (input source_sel, input divide_sel, input run, input alt_level,
                 input async_level, output tick);
    modport use_side (output source_sel, output divide_sel, output run, output alt_level,
                      output async_level, input tick);
endinterface

/* conv_clock_gen.sv */
// converter clock generator: source select and 1/2/4/8 divider as a tick
`timescale 1ns/1ps
module conv_clock_gen
    import adc_ctrl_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    conv_tick_if.gen tk
);
    typedef struct packed {
        logic half;
        logic alt_d;
        logic async_d;
        logic [2:0] cnt;
        logic tick;
    } gen_state_t;

    gen_state_t s;
    gen_state_t next_s;
    logic src_tick;
    logic [2:0] last;

    always_comb
    begin
        next_s = s;
        next_s.half = ~s.half;
        next_s.alt_d = tk.alt_level;
        next_s.async_d = tk.async_level;
        case (clk_src_t'(tk.source_sel))
            SRC_BUS: src_tick = 1'b1;
            SRC_BUS_HALF: src_tick = s.half;
            SRC_ALT: src_tick = tk.alt_level & ~s.alt_d;
            SRC_ASYNC: src_tick = tk.async_level & ~s.async_d;
            default: src_tick = 1'b0;
        endcase
        last = 3'((4'h1 << tk.divide_sel) - 4'h1);
        next_s.tick = 1'b0;
        // counter held while idle so the divider draws nothing between conversions
        if (!tk.run)
        begin
            next_s.cnt = 3'h0;
        end
        else if (src_tick)
        begin
            next_s.tick = (s.cnt == last);
            next_s.cnt = (s.cnt == last) ? 3'h0 : 3'(s.cnt + 3'h1);
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign tk.tick = s.tick;
endmodule

/* adc_conv_ctrl.sv */
// conversion control of a successive-approximation converter with register port
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
// ****************************************************************
// Overview of operation
// - converter held off during reset and while channel select is all ones
// - after a single conversion with no blocked transfer the block idles at lowest power until next start
// - approximation runs 12 raw bits in 12/10-bit modes, 9 in 8-bit
// - 10-bit mode rounds to 10 bits; 8-bit rounds to 8 in low byte only
// - result transfer sets complete flag; interrupt when enable bit set
// - clock source one of four; bus clock after reset
// - source codes: 00 bus, 01 bus half, 10 alternate, 11 async
// - selected source divided by 1, 2, 4 or 8
// - async clock kept running in wait and stop3 when selected and converting
// - mode codes: 00 8-bit, 01 12-bit, 10 10-bit, 11 reserved
// - pin-disable bits 0..7 map channels 16..23; one disables port control
// - disabled pin: output hi-z, input buffer and pullup off, reads zero
// - hardware trigger mode starts on each trigger rising edge seen while idle
// - trigger edge during a conversion is ignored
// - continuous hardware mode acts only on the launching edge
// - software mode starts on each control-one write unless channel off
// - continuous mode restarts after every transfer until aborted
// - high byte read, low unread, 12/10-bit: transfer blocked, result lost
// - blocked transfer launches another conversion unless aborted in the same cycle
// - single compare conversion failing the compare just stops
// - config/compare writes abort; control-one write aborts, then restarts in software mode
// - stop entry aborts unless async clock selected
// - abort keeps results; reset clears them
// - compare passes on result >= value or < value; else nothing stored
// - sample 4 or 24 converter clocks (3.5 or 23.5 rounded up) before approximation
// ****************************************************************
module adc_conv_ctrl
    import adc_ctrl_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [adc_ctrl_pkg::ADDR_W-1:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    input wire logic hw_trigger_in,
    input wire logic stop_mode_in,
    input wire logic alternate_clock_in,
    input wire logic async_clock_in,
    input wire logic compare_in,
    input wire logic [7:0] port_pins_in,
    output logic [11:0] trial_code_out,
    output logic sample_out,
    output logic conv_power_out,
    output logic async_clock_run_out,
    output logic irq_out,
    output logic [7:0] pin_hiz_out,
    output logic [7:0] pin_input_enable_out,
    output logic [7:0] pin_pullup_enable_out,
    output logic [7:0] port_read_out
);
    import adc_ctrl_pkg::*;

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        seq_t seq;
        logic [4:0] ch;
        logic complete_interrupt_enable;
        logic cont;
        logic conversion_complete_flag;
        logic trg;
        logic cfe;
        logic cfgt;
        logic [7:0] cfg;
        logic [7:0] cvh;
        logic [7:0] cvl;
        logic [7:0] rh;
        logic [7:0] rl;
        logic [7:0] pin_dis;
        logic [7:0] pin_keep;
        logic [7:0] port_rd;
        logic rh_pending;
        logic [2:0] trig;
        logic stop_d;
        logic [4:0] cnt;
        logic [3:0] bit_ix;
        logic [11:0] code;
        logic [7:0] rdata;
        logic irq;
        logic power;
        logic sampling;
        logic async_run;
    } ctrl_state_t;

    ctrl_state_t s;
    ctrl_state_t next_s;
    conv_tick_if tk ();

    conv_clock_gen u_clk (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .tk(tk)
    );

    conv_mode_t mode;
    clk_src_t src;
    logic wr_sc1;
    logic wr_cfgset;
    logic stop_abort;
    logic abort;
    logic trig_rise;
    logic sw_start;
    logic hw_start;
    logic done;
    logic [11:0] raw;
    logic [12:0] sum10;
    logic [9:0] sum8;
    logic [11:0] value;
    logic [11:0] cmp_val;
    logic [12:0] diff;
    logic [11:0] mask;
    logic [11:0] store;
    logic cmp_ok;
    logic blocked;

    assign mode = conv_mode_t'(s.cfg[CFG_MODE_LSB +: 2]);
    assign src = clk_src_t'(s.cfg[CFG_ICLK_LSB +: 2]);
    assign tk.source_sel = s.cfg[CFG_ICLK_LSB +: 2];
    assign tk.divide_sel = s.cfg[CFG_DIV_LSB +: 2];
    assign tk.run = (s.seq != SEQ_IDLE);
    assign tk.alt_level = alternate_clock_in;
    assign tk.async_level = async_clock_in;

    // ****************************************************************
    // result path: rounding and compare
    // ****************************************************************
    always_comb
    begin
        raw = s.code;
        if (!compare_in)
        begin
            raw[s.bit_ix] = 1'b0;
        end
        sum10 = 13'({1'b0, raw} + 13'h0002);
        sum8 = 10'({1'b0, raw[8:0]} + 10'h001);
        case (mode)
            MODE_10:
            begin
                value = {2'b00, (sum10[12] ? 10'h3ff : sum10[11:2])};
                cmp_val = {2'b00, s.cvh[1:0], s.cvl};
                mask = 12'h3ff;
            end
            MODE_8:
            begin
                value = {4'h0, (sum8[9] ? FULL_BYTE : sum8[8:1])};
                cmp_val = {4'h0, s.cvl};
                mask = 12'h0ff;
            end
            default:
            begin
                value = raw;
                cmp_val = {s.cvh[3:0], s.cvl};
                mask = 12'hfff;
            end
        endcase
        diff = 13'({1'b0, value} - {1'b0, cmp_val});
        cmp_ok = !s.cfe || (s.cfgt ? !diff[12] : diff[12]);
        store = s.cfe ? (diff[11:0] & mask) : value;
    end

    // ****************************************************************
    // control decode
    // ****************************************************************
    assign wr_sc1 = wr_in && (addr_in == OFS_SC1);
    assign wr_cfgset = wr_in && ((addr_in == OFS_SC2) || (addr_in == OFS_CFG)
                                 || (addr_in == OFS_CMP_HIGH) || (addr_in == OFS_CMP_LOW));
    assign stop_abort = stop_mode_in && !s.stop_d && (src != SRC_ASYNC);
    assign abort = wr_sc1 || wr_cfgset || stop_abort;
    assign trig_rise = s.trig[1] && !s.trig[2];
    assign sw_start = wr_sc1 && !s.trg && (wdata_in[4:0] != CH_OFF);
    // only an idle sequencer listens, so continuous runs see just the first edge
    assign hw_start = s.trg && trig_rise && (s.seq == SEQ_IDLE) && (s.ch != CH_OFF)
                      && !abort;
    assign done = (s.seq == SEQ_CONVERT) && tk.tick && (s.bit_ix == 4'h0);
    assign blocked = s.rh_pending && (mode != MODE_8);

    always_comb
    begin
        next_s = s;
        next_s.trig = {s.trig[1:0], hw_trigger_in};
        next_s.stop_d = stop_mode_in;
        next_s.rdata = ZERO_BYTE;

        // register reads with their side effects
        if (rd_in)
        begin
            case (addr_in)
                OFS_SC1: next_s.rdata = {s.conversion_complete_flag, s.complete_interrupt_enable, s.cont, s.ch};
                OFS_SC2: next_s.rdata = {s.seq != SEQ_IDLE, s.trg, s.cfe, s.cfgt, 4'h0};
                OFS_RES_HIGH:
                begin
                    next_s.rdata = s.rh;
                    next_s.rh_pending = (mode != MODE_8);
                end
                OFS_RES_LOW:
                begin
                    next_s.rdata = s.rl;
                    next_s.rh_pending = 1'b0;
                    next_s.conversion_complete_flag = 1'b0;
                end
                OFS_CMP_HIGH: next_s.rdata = s.cvh;
                OFS_CMP_LOW: next_s.rdata = s.cvl;
                OFS_CFG: next_s.rdata = s.cfg;
                OFS_PIN_DIS: next_s.rdata = s.pin_dis;
                default: next_s.rdata = ZERO_BYTE;
            endcase
        end

        if (wr_in)
        begin
            case (addr_in)
                OFS_SC1:
                begin
                    next_s.complete_interrupt_enable = wdata_in[SC1_COMPLETE_INTERRUPT_ENABLE_BIT];
                    next_s.cont = wdata_in[SC1_CONT_BIT];
                    next_s.ch = wdata_in[4:0];
                    next_s.conversion_complete_flag = 1'b0;
                end
                OFS_SC2:
                begin
                    next_s.trg = wdata_in[SC2_TRG_BIT];
                    next_s.cfe = wdata_in[SC2_CFE_BIT];
                    next_s.cfgt = wdata_in[SC2_CFGT_BIT];
                end
                OFS_CMP_HIGH: next_s.cvh = wdata_in;
                OFS_CMP_LOW: next_s.cvl = wdata_in;
                OFS_CFG: next_s.cfg = wdata_in;
                OFS_PIN_DIS: next_s.pin_dis = wdata_in;
                default: next_s.cfg = s.cfg;
            endcase
        end

        // ****************************************************************
        // sequencer
        // ****************************************************************
        case (s.seq)
            SEQ_SAMPLE:
            begin
                if (tk.tick)
                begin
                    next_s.cnt = 5'(s.cnt - 5'h01);
                    if (s.cnt == 5'h01)
                    begin
                        next_s.seq = SEQ_CONVERT;
                        next_s.bit_ix = (mode == MODE_8) ? MSB_9 : MSB_12;
                        next_s.code = 12'h001 << ((mode == MODE_8) ? MSB_9 : MSB_12);
                    end
                end
            end
            SEQ_CONVERT:
            begin
                if (tk.tick && !done)
                begin
                    next_s.code = raw;
                    next_s.bit_ix = 4'(s.bit_ix - 4'h1);
                    next_s.code[s.bit_ix - 4'h1] = 1'b1;
                end
                if (done)
                begin
                    next_s.seq = SEQ_IDLE;
                    if (s.cfe && !cmp_ok && !s.cont)
                    begin
                        next_s.seq = SEQ_IDLE;
                    end
                    else if (cmp_ok && blocked)
                    begin
                        next_s.seq = SEQ_SAMPLE;
                    end
                    else
                    begin
                        if (cmp_ok && !abort)
                        begin
                            next_s.rh = (mode == MODE_8) ? ZERO_BYTE : {4'h0, store[11:8]};
                            next_s.rl = store[7:0];
                            next_s.conversion_complete_flag = 1'b1;
                        end
                        if (s.cont)
                        begin
                            next_s.seq = SEQ_SAMPLE;
                        end
                    end
                    next_s.cnt = s.cfg[CFG_LSMP_BIT] ? SAMPLE_LONG_TICKS : SAMPLE_SHORT_TICKS;
                end
            end
            SEQ_IDLE:
            begin
                if (hw_start)
                begin
                    next_s.seq = SEQ_SAMPLE;
                end
            end
            default: next_s.seq = SEQ_IDLE;
        endcase

        // abort wins over any progress; results stay as they were
        if (abort)
        begin
            next_s.seq = sw_start ? SEQ_SAMPLE : SEQ_IDLE;
        end
        if (next_s.seq == SEQ_SAMPLE && s.seq != SEQ_SAMPLE)
        begin
            next_s.cnt = next_s.cfg[CFG_LSMP_BIT] ? SAMPLE_LONG_TICKS : SAMPLE_SHORT_TICKS;
        end
        if (next_s.ch == CH_OFF)
        begin
            next_s.seq = SEQ_IDLE;
        end

        next_s.irq = next_s.conversion_complete_flag && next_s.complete_interrupt_enable;
        next_s.power = (next_s.seq != SEQ_IDLE);
        next_s.sampling = (next_s.seq == SEQ_SAMPLE);
        next_s.async_run = next_s.power
                           && (next_s.cfg[CFG_ICLK_LSB +: 2] == SRC_ASYNC);
        next_s.pin_keep = ~next_s.pin_dis;
        next_s.port_rd = port_pins_in & ~next_s.pin_dis;
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            s <= '0;
            s.ch <= CH_OFF;
            s.pin_keep <= FULL_BYTE;
        end
        else
        begin
            s <= next_s;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign rdata_out = s.rdata;
    assign trial_code_out = s.code;
    assign sample_out = s.sampling;
    assign conv_power_out = s.power;
    assign async_clock_run_out = s.async_run;
    assign irq_out = s.irq;
    assign pin_hiz_out = s.pin_dis;
    assign pin_input_enable_out = s.pin_keep;
    assign pin_pullup_enable_out = s.pin_keep;
    assign port_read_out = s.port_rd;

    // ****************************************************************
    // checks
    // ****************************************************************
    channel_off_idle_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (s.ch == CH_OFF) |-> (s.seq == SEQ_IDLE && !conv_power_out))
        else $error("converter active with channel off");
    idle_low_power_a: assert property (@(posedge clk_in) disable iff (rst_in)
        done && !s.cont && !blocked && !abort |=> !conv_power_out)
        else $error("power kept after single conversion");
    conversion_complete_flag_irq_a: assert property (@(posedge clk_in) disable iff (rst_in)
        done && cmp_ok && !blocked && s.complete_interrupt_enable && !abort |=> s.conversion_complete_flag && irq_out)
        else $error("complete flag or interrupt missing");
    busy_edge_ignored_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (s.seq == SEQ_CONVERT) && trig_rise && !wr_in && !done |=> s.seq == SEQ_CONVERT)
        else $error("trigger edge disturbed a conversion");
    cfg_abort_keep_a: assert property (@(posedge clk_in) disable iff (rst_in)
        wr_cfgset |=> (s.seq == SEQ_IDLE) && (s.rh == $past(s.rh)) && (s.rl == $past(s.rl)))
        else $error("config write did not abort or changed results");
    sw_restart_a: assert property (@(posedge clk_in) disable iff (rst_in)
        sw_start |=> (s.seq == SEQ_SAMPLE) && sample_out)
        else $error("software start missed");
    blocked_drop_a: assert property (@(posedge clk_in) disable iff (rst_in)
        done && blocked && cmp_ok && !abort && !rd_in
        |=> (s.conversion_complete_flag == $past(s.conversion_complete_flag)) && s.seq == SEQ_SAMPLE)
        else $error("blocked transfer not discarded and restarted");
    stop_abort_a: assert property (@(posedge clk_in) disable iff (rst_in)
        stop_abort |=> s.seq == SEQ_IDLE)
        else $error("stop entry did not abort");
    reset_results_a: assert property (@(posedge clk_in)
        rst_in |=> (s.rh == ZERO_BYTE) && (s.rl == ZERO_BYTE) && !irq_out)
        else $error("results not cleared by reset");
    pin_read_zero_a: assert property (@(posedge clk_in) disable iff (rst_in)
        ##1 ((port_read_out & pin_hiz_out) == ZERO_BYTE) && (pin_input_enable_out == ~pin_hiz_out))
        else $error("disabled pin not isolated");
endmodule

/* sar_core_model.sv */
// behavioural analog core: ideal comparator against a settable input level
`timescale 1ns/1ps
module sar_core_model
(
    input wire logic [11:0] trial_code_in,
    input wire logic [11:0] level_in,
    output logic compare_out
);
    // zero-delay answer; the sequencer samples it on its own tick
    assign compare_out = (level_in >= trial_code_in);
endmodule

/* test_adc_conversion_control.sv */
// self-checking bench for the conversion control block
`timescale 1ns/1ps
module test_adc_conversion_control;
    import adc_ctrl_pkg::*;
    logic clk_in = 0, rst_in = 1, wr = 0, rd = 0, hw = 0, stop = 0, alt = 0;
    logic [2:0] addr = '0;
    logic [7:0] wdata = '0, pins = 8'hff, d, rdata, hiz, ien, pen, prd;
    logic [11:0] trial, level = '0;
    logic cmp, power, arun, irq, smp;
    int error_cnt = 0, n_checks = 0, cyc = 0, i;
    // cfg, level, expected high, expected low
    logic [35:0] tbl [9] = '{36'h00_0AB_00_56, 36'h00_1FF_00_FF, 36'h24_A5C_0A_5C,
        36'h08_9C6_02_72, 36'h08_FFF_03_FF, 36'h0C_123_01_23, 36'h6A_2F0_00_BC,
        36'h15_567_05_67, 36'h07_89A_08_9A};
    adc_conv_ctrl DUT (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr), .wdata_in(wdata),
        .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .hw_trigger_in(hw), .stop_mode_in(stop),
        .alternate_clock_in(alt), .async_clock_in(alt), .compare_in(cmp),
        .port_pins_in(pins), .trial_code_out(trial), .sample_out(smp),
        .conv_power_out(power), .async_clock_run_out(arun), .irq_out(irq),
        .pin_hiz_out(hiz), .pin_input_enable_out(ien), .pin_pullup_enable_out(pen),
        .port_read_out(prd));
    sar_core_model CORE (.trial_code_in(trial), .level_in(level), .compare_out(cmp));
    initial forever #2.5 clk_in = ~clk_in;
    // alt doubles as the async clock: one source tick every second bus cycle
    always @(posedge clk_in)
    begin
        cyc <= cyc + 1;
        alt <= ~alt;
        if (cyc == 20000)
        begin
            error_cnt++;
            end_of_test();
        end
    end
    task chk(input logic [11:0] seen, input logic [11:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task wrr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk_in);
        wr <= 1;
        addr <= a;
        wdata <= v;
        @(posedge clk_in);
        wr <= 0;
    endtask
    task rdd(input logic [2:0] a);
        @(posedge clk_in);
        rd <= 1;
        addr <= a;
        @(posedge clk_in);
        rd <= 0;
        #1 d = rdata;
    endtask
    task wt(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task pulse;
        @(posedge clk_in);
        hw <= 1;
        repeat (3) @(posedge clk_in);
        hw <= 0;
    endtask
    task wait_done;
        int p;
        for (p = 0; p < 400; p++)
        begin
            rdd(OFS_SC1);
            if (d[SC1_CONVERSION_COMPLETE_FLAG_BIT] === 1'b1)
                break;
        end
        chk(d[SC1_CONVERSION_COMPLETE_FLAG_BIT], 1);
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // ****************************************************************
    // tests
    // ****************************************************************
    initial
    begin
        repeat (6) @(posedge clk_in);
        rst_in <= 0;
        wt(1);
        for (i = 0; i < 8; i++)
        begin
            rdd(3'(i));
            chk(d, (i == 0) ? 12'h01f : 12'h000);
        end
        chk(ien, 8'hff);
        chk(power, 0);
        $display("done: reset values");
        wrr(OFS_PIN_DIS, 8'ha5);
        wt(2);
        chk(hiz, 8'ha5);
        chk(ien, 8'h5a);
        chk(pen, 8'h5a);
        chk(prd, 8'h5a);
        rdd(OFS_PIN_DIS);
        chk(d, 8'ha5);
        $display("done: pin control");
        foreach (tbl[k])
        begin
            wrr(OFS_CFG, tbl[k][35:28]);
            level <= tbl[k][27:16];
            wrr(OFS_SC1, 8'h45);
            wait_done();
            chk(irq, 1);
            rdd(OFS_RES_HIGH);
            chk(d, tbl[k][15:8]);
            rdd(OFS_RES_LOW);
            chk(d, tbl[k][7:0]);
            wt(2);
            chk(irq, 0);
        end
        $display("done: modes and clocks");
        wrr(OFS_CFG, 8'h64);
        level <= 12'h333;
        wrr(OFS_SC1, 8'h05);
        wt(20);
        chk(power, 1);
        wrr(OFS_CFG, 8'h04);
        wt(3);
        chk(power, 0);
        rdd(OFS_RES_HIGH);
        chk(d, 8'h08);
        rdd(OFS_RES_LOW);
        chk(d, 8'h9a);
        wrr(OFS_SC1, 8'h05);
        wt(3);
        stop <= 1;
        wt(3);
        chk(power, 0);
        stop <= 0;
        wrr(OFS_CFG, 8'h07);
        wrr(OFS_SC1, 8'h05);
        wt(4);
        chk(arun, 1);
        stop <= 1;
        wt(4);
        chk(power, 1);
        wait_done();
        stop <= 0;
        $display("done: aborts");
        wrr(OFS_CFG, 8'h04);
        level <= 12'h111;
        wrr(OFS_SC1, 8'h05);
        wait_done();
        level <= 12'h222;
        wrr(OFS_SC1, 8'h05);
        rdd(OFS_RES_HIGH);
        chk(d, 8'h01);
        wt(40);
        rdd(OFS_SC1);
        chk(d[SC1_CONVERSION_COMPLETE_FLAG_BIT], 0);
        chk(power, 1);
        rdd(OFS_RES_LOW);
        chk(d, 8'h11);
        wait_done();
        rdd(OFS_RES_HIGH);
        chk(d, 8'h02);
        rdd(OFS_RES_LOW);
        chk(d, 8'h22);
        $display("done: blocking");
        level <= 12'h4c4;
        wrr(OFS_SC1, 8'h25);
        wait_done();
        level <= 12'h5d5;
        wt(40);
        rdd(OFS_RES_HIGH);
        chk(d, 8'h05);
        rdd(OFS_RES_LOW);
        chk(d, 8'hd5);
        wrr(OFS_SC1, 8'h3f);
        wt(3);
        chk(power, 0);
        $display("done: continuous");
        wrr(OFS_SC2, 8'h40);
        wrr(OFS_SC1, 8'h05);
        wt(3);
        chk(power, 0);
        pulse();
        wt(4);
        pulse();
        wt(60);
        chk(power, 0);
        rdd(OFS_SC1);
        chk(d[SC1_CONVERSION_COMPLETE_FLAG_BIT], 1);
        $display("done: hardware trigger");
        end_of_test();
    end
endmodule
